// [rtl/wdt_top.sv]
// watchdog control register and timeout action of the microcontroller
`timescale 1ns/1ps
`include "wdt_defs.svh"

module wdt_top (
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              xtal_in,
    input  wdt_pkg::sfr_req_s      sfr_req,
    output logic [7:0]             sfr_rdata,
    output logic                   wdt_reset,
    output logic                   wdt_irq
);
    import wdt_pkg::*;

    typedef struct packed {
        watchdog_control_s ctrl;
        logic [7:0]        rdata;
        logic              rst_pulse;
        logic              irq_pulse;
        logic              restart;
    } top_s;

    top_s s_q;
    top_s s_d;
    logic timeout;
    logic hit;
    logic any_wr;
    logic [7:0] wbyte;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // byte write or single bit write (set/clear bit instructions)
    function automatic logic [7:0] merge_write(input logic [7:0] cur, input sfr_req_s r);
        logic [7:0] v;
        v = cur;
        if (r.bit_wr) begin
            v[r.bit_sel] = r.bit_val;
        end else begin
            v = r.wdata;
        end
        return v;
    endfunction

    assign hit    = (sfr_req.addr == `WDT_CTRL_ADDR);
    assign any_wr = sfr_req.wr | sfr_req.bit_wr;
    assign wbyte  = merge_write(s_q.ctrl, sfr_req);

    // --------------------------------------------------------------
    // timer
    // --------------------------------------------------------------
    wdt_timer i_wdt_timer (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .xtal_in  (xtal_in),
        .run      (s_q.ctrl.watchdog_enable_bit),
        .restart  (s_q.restart),
        .prescale (s_q.ctrl.timeout_prescale_field),
        .timeout  (timeout)
    );

    // --------------------------------------------------------------
    // control register
    // --------------------------------------------------------------
    always_comb begin
        s_d           = s_q;
        s_d.rst_pulse = 1'b0;
        s_d.irq_pulse = 1'b0;
        s_d.restart   = 1'b0;
        s_d.rdata     = hit ? s_q.ctrl : 8'h00;

        if (any_wr) begin
            if (s_q.ctrl.write_unlock_bit) begin
                // the unlock is spent by whatever write comes next
                s_d.ctrl.write_unlock_bit = 1'b0;
                if (hit) begin
                    s_d.ctrl.timeout_prescale_field =
                        wbyte[`WDT_PRE_MSB:`WDT_PRE_LSB];
                    s_d.ctrl.action_select_bit   = wbyte[`WDT_SEL_BIT];
                    s_d.ctrl.watchdog_enable_bit = wbyte[`WDT_EN_BIT];
                    // software may only clear the status flag
                    if (!wbyte[`WDT_STAT_BIT]) begin
                        s_d.ctrl.timeout_status_flag = 1'b0;
                    end
                    if (wbyte[`WDT_EN_BIT]) begin
                        s_d.restart = 1'b1;
                    end
                end
            end else if (hit && wbyte[`WDT_UNLOCK_BIT]) begin
                // only the unlock bit itself may be set while locked
                s_d.ctrl.write_unlock_bit = 1'b1;
            end
        end

        // a timeout wins over a clearing write in the same cycle
        if (timeout && s_q.ctrl.watchdog_enable_bit) begin
            s_d.ctrl.timeout_status_flag = 1'b1;
            if (s_q.ctrl.action_select_bit) begin
                s_d.irq_pulse = 1'b1;
            end else begin
                s_d.rst_pulse                = 1'b1;
                s_d.ctrl.watchdog_enable_bit = 1'b0;
                s_d.restart                  = 1'b0;
            end
        end
    end

    // the watchdog reset it issues must not reach reset_n, or status would be lost
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{ctrl: `WDT_CTRL_RESET, rdata: 8'h00, rst_pulse: 1'b0,
                     irq_pulse: 1'b0, restart: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata = s_q.rdata;
    assign wdt_reset = s_q.rst_pulse;
    assign wdt_irq   = s_q.irq_pulse;

endmodule

// [rtl/wdt_defs.svh]
// register offset, field positions, reset value and timing counts of the watchdog
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

`define WDT_CTRL_ADDR      8'hc0
`define WDT_CTRL_RESET     8'h10
`define WDT_PRE_MSB        7
`define WDT_PRE_LSB        4
`define WDT_SEL_BIT        3
`define WDT_STAT_BIT       2
`define WDT_EN_BIT         1
`define WDT_UNLOCK_BIT     0
`define WDT_BASE_LOG2      9
`define WDT_PRE_MAX_VALID  4'h7
`define WDT_PRE_IMMEDIATE  4'h8
`define WDT_CNT_W          16

`endif

// [rtl/wdt_pkg.sv]
// types shared by the watchdog modules
package wdt_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
        logic       bit_wr;
        logic [2:0] bit_sel;
        logic       bit_val;
    } sfr_req_s;

    typedef struct packed {
        logic [3:0] timeout_prescale_field;
        logic       action_select_bit;
        logic       timeout_status_flag;
        logic       watchdog_enable_bit;
        logic       write_unlock_bit;
    } watchdog_control_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COUNT,
        ST_FIRE
    } tmr_state_e;

endpackage

// [rtl/wdt_timer.sv]
// crystal-timed timeout counter of the watchdog
`timescale 1ns/1ps
`include "wdt_defs.svh"

module wdt_timer #(
    parameter int CNT_W = `WDT_CNT_W
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       xtal_in,
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [3:0] prescale,
    output logic            timeout
);
    import wdt_pkg::*;

    typedef struct packed {
        logic [2:0]       xs;
        logic [CNT_W-1:0] cnt;
        tmr_state_e       st;
        logic             fire;
    } tmr_s;

    tmr_s s_q;
    tmr_s s_d;
    logic [CNT_W-1:0] limit;
    logic             xtal_rise;

    // --------------------------------------------------------------
    // terminal count
    // --------------------------------------------------------------
    // reserved prescale codes above the immediate code also fire at once
    always_comb begin
        if (prescale > `WDT_PRE_MAX_VALID) begin
            limit = '0;
        end else begin
            limit = CNT_W'((32'd1 << (`WDT_BASE_LOG2 + 32'(prescale))) - 32'd1);
        end
    end

    // xs[0] feeds xs[1] only; edge is seen between xs[1] and xs[2]
    assign xtal_rise = s_q.xs[1] & ~s_q.xs[2];

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.xs   = {s_q.xs[1:0], xtal_in};
        s_d.fire = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                s_d.cnt = '0;
                if (run) begin
                    s_d.st = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (!run) begin
                    s_d.st  = ST_IDLE;
                    s_d.cnt = '0;
                end else if (restart) begin
                    s_d.cnt = '0;
                end else if (s_q.cnt >= limit) begin
                    s_d.st   = ST_FIRE;
                    s_d.fire = 1'b1;
                    s_d.cnt  = '0;
                end else if (xtal_rise) begin
                    s_d.cnt = s_q.cnt + CNT_W'(1);
                end
            end
            ST_FIRE: begin
                // one cycle in ST_FIRE before recount; run sampled here is still the value from before the control register reacts
                s_d.st = run ? ST_COUNT : ST_IDLE;
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{xs: 3'h0, cnt: '0, st: ST_IDLE, fire: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign timeout = s_q.fire;

endmodule

// [verif/wdt_top_checker.sv]
// port assertions of the watchdog top
`timescale 1ns/1ps
module wdt_top_checker (
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              xtal_in,
    input  wire wdt_pkg::sfr_req_s sfr_req,
    input  wire logic [7:0]        sfr_rdata,
    input  wire logic              wdt_reset,
    input  wire logic              wdt_irq
);
    import wdt_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ----
    // plain read of the control register, no write in the same cycle
    // ----
    logic rd_c0;
    assign rd_c0 = sfr_req.addr == 8'hc0 && !sfr_req.wr && !sfr_req.bit_wr;
    a_reset_one_pulse: assert property (wdt_reset |=> !wdt_reset)
        else $error("reset pulse too long");
    a_irq_one_pulse: assert property (wdt_irq |=> !wdt_irq)
        else $error("irq pulse too long");
    a_single_action: assert property (!(wdt_reset && wdt_irq))
        else $error("reset and irq together");
    a_reset_clears_en: assert property (wdt_reset && rd_c0 |=> sfr_rdata[2:1] == 2'b10)
        else $error("status or enable wrong after reset");
    a_irq_sets_status: assert property (wdt_irq && rd_c0 |=> sfr_rdata[2:1] == 2'b11)
        else $error("status or enable wrong after irq");
    a_other_addr_zero: assert property (sfr_req.addr != 8'hc0 |=> sfr_rdata == 8'h00)
        else $error("read of other address not zero");
    a_reset_value: assert property (!$past(reset_n) && rd_c0 |=> sfr_rdata == 8'h10)
        else $error("wrong reset value");
    a_quiet_when_off: assert property (wdt_reset ##1 (!sfr_req.wr && !sfr_req.bit_wr)[*6]
        |-> !wdt_reset && !wdt_irq) else $error("action while disabled");
endmodule

bind wdt_top wdt_top_checker i_wdt_top_checker (.mclk(mclk), .reset_n(reset_n),
    .xtal_in(xtal_in), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .wdt_reset(wdt_reset),
    .wdt_irq(wdt_irq));

// [verif/wdt_top_test.sv]
// self-checking bench of the watchdog top
`timescale 1ns/1ps
module wdt_top_test;
    import wdt_pkg::*;
    logic        mclk = 0, reset_n = 0, xtal_in = 0, xt_run = 0;
    // the address already points at the register when reset lets go
    sfr_req_s    sfr_req = '{addr: 8'hc0, default: '0};
    logic [7:0]  sfr_rdata, cur = 8'h10, a;
    logic        wdt_reset, wdt_irq;
    logic [31:0] seed = 32'h1ef5;
    logic [1:0]  ph = 0;
    int          n_mismatch = 0, compares = 0, n_rst = 0, n_irq = 0, rises = 0, r0;

    wdt_top i_wdt_top (.mclk(mclk), .reset_n(reset_n), .xtal_in(xtal_in), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .wdt_reset(wdt_reset), .wdt_irq(wdt_irq));

    always #20 mclk = ~mclk;
    // crystal stand-in: period of 4 core cycles keeps it well inside the synchroniser's reach
    always @(negedge mclk) begin
        ph <= ph + 2'h1;
        if (xt_run && ph[0]) begin
            xtal_in <= ~xtal_in;
            rises   <= rises + int'(!xtal_in);
        end
    end
    always @(posedge mclk) begin
        n_rst += int'(wdt_reset === 1'b1);
        n_irq += int'(wdt_irq === 1'b1);
    end
    // ----
    // helpers
    // ----
    function logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // status can only be cleared by software, unlock always reads back clear
    function logic [7:0] wr_val(logic [7:0] c, logic [7:0] v);
        return {v[7:3], v[2] & c[2], v[1], 1'b0};
    endfunction
    task chk(logic [7:0] got, logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(logic [7:0] ad, logic [7:0] v);
        @(negedge mclk);
        sfr_req.addr  = ad;
        sfr_req.wdata = v;
        sfr_req.wr    = 1'b1;
        @(negedge mclk);
        sfr_req.wr    = 1'b0;
    endtask
    task bw(logic [2:0] sel, logic v);
        @(negedge mclk);
        sfr_req.addr    = 8'hc0;
        sfr_req.bit_sel = sel;
        sfr_req.bit_val = v;
        sfr_req.bit_wr  = 1'b1;
        @(negedge mclk);
        sfr_req.bit_wr  = 1'b0;
    endtask
    task unl;
        bw(3'h0, 1'b1);
    endtask
    task uw(logic [7:0] v);
        r0 = rises;
        unl;
        wr(8'hc0, v);
        cur = wr_val(cur, v);
    endtask
    task rd(logic [7:0] ad, logic [7:0] exp);
        @(negedge mclk);
        sfr_req.addr = ad;
        @(negedge mclk);
        chk(sfr_rdata, exp);
        sfr_req.addr = 8'hc0;
    endtask
    task fire(int lo, int hi, logic irq);
        int c0, i0, k;
        c0 = n_rst + n_irq;
        i0 = n_irq;
        for (k = 0; k < 9000 && n_rst + n_irq == c0; k++) @(negedge mclk);
        chk(8'(n_rst + n_irq - c0), 8'h01);
        chk(8'(n_irq - i0), {7'h0, irq});
        chk({7'h0, rises - r0 >= lo && rises - r0 <= hi}, 8'h01);
    endtask
    task end_of_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    initial begin
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        rd(8'hc0, 8'h10);
        xt_run = 1'b1;
        wr(8'hc0, 8'h02);
        repeat (2100) @(negedge mclk);
        chk(8'(n_rst + n_irq), 8'h00);
        rd(8'hc0, 8'h10);
        repeat (4) begin
            seed = lfsr(seed);
            a = seed[7:0] ^ {7'h0, seed[7:0] == 8'hc0};
            unl;
            wr(a, seed[15:8]);
            wr(8'hc0, 8'h02);
            rd(a, 8'h00);
            rd(8'hc0, cur);
        end
        uw(8'h02);
        repeat (1400) @(negedge mclk);
        chk(8'(n_rst + n_irq), 8'h00);
        uw(8'h02);
        fire(511, 514, 1'b0);
        rd(8'hc0, 8'h04);
        cur = 8'h04;
        uw(8'h1a);
        fire(1023, 1026, 1'b1);
        rd(8'hc0, 8'h1e);
        cur = 8'h1e;
        // single-bit clear of the status flag after an unlock
        unl;
        bw(3'h2, 1'b0);
        rd(8'hc0, 8'h1a);
        cur = 8'h1a;
        uw(8'h18);
        rd(8'hc0, cur);
        uw(8'h82);
        fire(0, 3, 1'b0);
        rd(8'hc0, 8'h84);
        // external reset after the timeout reset action has stopped the watchdog must clear the status flag
        @(negedge mclk);
        reset_n = 1'b0;
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        rd(8'hc0, 8'h10);
        end_of_test;
    end
    initial begin
        #1000000;
        n_mismatch++;
        end_of_test;
    end
endmodule
